// File: verilog/vra_pkg.sv
// Shared constants and types for the aliased vector register file
package vra_pkg;
  localparam int MAX_VECTOR_LENGTH   = 512;           // Full register width in bits
  localparam int VEC_BYTES           = 64;            // Bytes per full register
  localparam int VEC128_BYTES        = 16;            // Bytes in the vec128 view
  localparam int VEC256_BYTES        = 32;            // Bytes in the vec256 view
  localparam int NUM_VREGS           = 32;            // Registers reachable in 64-bit mode
  localparam int NUM_VREGS_LEGACY    = 8;             // Registers reachable outside 64-bit mode
  localparam int NUM_MASK_REGS       = 8;             // Mask register count
  localparam int MASK_REGISTER_WIDTH = 64;            // Bits per mask register
  localparam int DISP_W              = 32;            // Effective displacement width
  localparam logic [2:0] MASK_NONE   = 3'h0;          // Predicate field meaning no masking
  localparam logic [511:0] VREG_RST  = 512'h0;        // Vector register reset value
  localparam logic [63:0]  MASK_RST  = 64'h0;         // Mask register reset value
  localparam logic [63:0]  ALL_ONES  = 64'hffffffffffffffff; // Unmasked predicate

  // Instruction encoding class and vector length
  typedef enum logic [2:0] {
    ENC_LEGACY, ENC_SHORT_128, ENC_SHORT_256, ENC_EXT_128, ENC_EXT_256, ENC_EXT_512
  } vra_enc_t;

  // Element size: 8, 16, 32 or 64 bits (log2 of bytes)
  typedef enum logic [1:0] {ESZ_8, ESZ_16, ESZ_32, ESZ_64} vra_esz_t;

  // Read view width
  typedef enum logic [1:0] {VIEW_128, VIEW_256, VIEW_512} vra_view_t;

  // Per-byte action on a write
  typedef enum logic [1:0] {ACT_KEEP, ACT_WRITE, ACT_ZERO} vra_act_t;

  // Decoded instruction controls from the pipeline
  typedef struct packed {
    vra_enc_t    enc;        // Encoding class and length
    vra_esz_t    esz;        // Element size
    logic [2:0]  mask_sel;   // Predicate mask register
    logic        zeroing;    // Zeroing (1) or merging (0) masking
    logic        bcast;      // Replicate element zero
    logic        rr_form;    // Register-to-register form
    logic        scalar;     // Scalar instruction
    logic        rc_static;  // Prefix carries a rounding mode
    logic [1:0]  rc_mode;    // Rounding mode from the prefix
    logic        disp8_mode; // Compressed displacement in use
    logic [7:0]  disp8;      // Compressed displacement
    logic [31:0] full_displacement; // Full displacement
  } vra_op_t;
endpackage : vra_pkg

// File: verilog/vra_regfile.sv
// Aliased vector register file with mask registers and predication
module vra_regfile (
  input  wire logic             i_mclk,       // Core clock
  input  wire logic             i_arst_n,     // Async reset, active low
  input  wire logic             i_ce,         // Clock enable, freezes all state
  input  wire logic             i_mode64,     // 64-bit operating mode
  input  wire vra_pkg::vra_op_t i_op,         // Current instruction controls
  input  wire logic             i_wr_en,      // Vector register write
  input  wire logic [4:0]       i_wr_idx,     // Destination register
  input  wire logic [511:0]     i_wr_data,    // Result data
  input  wire logic [4:0]       i_rd_idx,     // Source register
  input  wire vra_pkg::vra_view_t i_rd_view,  // Source view width
  input  wire logic             i_kw_en,      // Mask register write
  input  wire logic [2:0]       i_kw_idx,     // Mask register written
  input  wire logic [63:0]      i_kw_data,    // Mask write data
  input  wire logic [2:0]       i_kr_idx,     // Mask register read
  input  wire logic [1:0]       i_fpcsr_rc,   // Rounding field of fp_control_status_reg
  input  wire logic [63:0]      i_elem_exc,   // Raw per-element exception flags
  output logic [511:0]          o_rd_data,    // Read data, zero above view
  output logic [63:0]           o_kr_data,    // Mask read data
  output logic [63:0]           o_elem_en,    // Per-element enables for memory access
  output logic                  o_exc_any,    // Exception from an active element
  output logic [1:0]            o_rnd_mode,   // Rounding mode in force
  output logic [31:0]           o_disp        // Effective displacement
);

  // Bytes covered by an encoding's vector length
  function automatic int vl_bytes(input vra_pkg::vra_enc_t e);
    case (e)
      vra_pkg::ENC_SHORT_256, vra_pkg::ENC_EXT_256: vl_bytes = vra_pkg::VEC256_BYTES;
      vra_pkg::ENC_EXT_512:                         vl_bytes = vra_pkg::VEC_BYTES;
      default:                                      vl_bytes = vra_pkg::VEC128_BYTES;
    endcase
  endfunction : vl_bytes

  // True for the extended prefix classes
  function automatic logic is_ext(input vra_pkg::vra_enc_t e);
    is_ext = (e == vra_pkg::ENC_EXT_128) || (e == vra_pkg::ENC_EXT_256) ||
             (e == vra_pkg::ENC_EXT_512);
  endfunction : is_ext

  // Action for one byte of the destination
  function automatic vra_pkg::vra_act_t byte_act(input vra_pkg::vra_enc_t e, input int b,
                                                 input logic en, input logic zero);
    if (e == vra_pkg::ENC_LEGACY) begin
      byte_act = (b < vra_pkg::VEC128_BYTES) ? vra_pkg::ACT_WRITE : vra_pkg::ACT_KEEP;
    end else if (b >= vl_bytes(e)) begin
      byte_act = vra_pkg::ACT_ZERO;
    end else if (en) begin
      byte_act = vra_pkg::ACT_WRITE;
    end else begin
      byte_act = zero ? vra_pkg::ACT_ZERO : vra_pkg::ACT_KEEP;
    end
  endfunction : byte_act

  // Replicate element zero of the given size across the vector
  function automatic logic [511:0] bcast(input logic [511:0] d, input vra_pkg::vra_esz_t s);
    int sz;
    sz = 1 << int'(s);
    bcast = '0;
    for (int b = 0; b < vra_pkg::VEC_BYTES; b++) begin
      bcast[8*b +: 8] = d[8*(b % sz) +: 8];
    end
  endfunction : bcast

  // Storage
  logic [511:0] vreg_reg [vra_pkg::NUM_VREGS];      // Full-width vector registers
  logic [63:0]  kreg_reg [vra_pkg::NUM_MASK_REGS];  // Mask registers

  // Decoded controls
  logic [4:0]   widx;        // Effective write index
  logic [4:0]   ridx;        // Effective read index
  logic [63:0]  pred;        // Predicate before length limit
  logic [63:0]  elem_en;     // Active elements
  logic [63:0]  byte_en;     // Active elements expanded to bytes
  logic [511:0] wdata;       // Write data after broadcast
  logic         use_static;  // Prefix rounding in force
  int           nelem;       // Element count at this length
  int           dscale;      // Compressed displacement scale

  // Register index width depends on the mode
  always_comb begin
    widx = i_mode64 ? i_wr_idx : {2'b00, i_wr_idx[2:0]};
    ridx = i_mode64 ? i_rd_idx : {2'b00, i_rd_idx[2:0]};
  end

  // Predicate and element enables
  always_comb begin
    if (is_ext(i_op.enc) && (i_op.mask_sel != vra_pkg::MASK_NONE)) begin
      pred = kreg_reg[i_op.mask_sel];
    end else begin
      pred = vra_pkg::ALL_ONES;
    end
    nelem = vl_bytes(i_op.enc) >> int'(i_op.esz);
    if (i_op.scalar) begin
      nelem = 1;
    end
    elem_en = '0;
    for (int i = 0; i < vra_pkg::MASK_REGISTER_WIDTH; i++) begin
      elem_en[i] = pred[i] && (i < nelem);
    end
    byte_en = '0;
    for (int b = 0; b < vra_pkg::VEC_BYTES; b++) begin
      byte_en[b] = elem_en[b >> int'(i_op.esz)];
    end
    wdata = i_op.bcast ? bcast(i_wr_data, i_op.esz) : i_wr_data;
  end

  // Rounding source and displacement scale
  always_comb begin
    use_static = is_ext(i_op.enc) && i_op.rr_form && i_op.rc_static &&
                 ((i_op.enc == vra_pkg::ENC_EXT_512) || i_op.scalar);
    if (i_op.bcast || i_op.scalar) begin
      dscale = 1 << int'(i_op.esz);
    end else begin
      dscale = vl_bytes(i_op.enc);
    end
  end

  // Vector register writes, one byte lane at a time
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int r = 0; r < vra_pkg::NUM_VREGS; r++) begin
        vreg_reg[r] <= vra_pkg::VREG_RST;
      end
    end else if (i_ce && i_wr_en) begin
      for (int b = 0; b < vra_pkg::VEC_BYTES; b++) begin
        case (byte_act(i_op.enc, b, byte_en[b], i_op.zeroing))
          vra_pkg::ACT_WRITE: begin
            vreg_reg[widx][8*b +: 8] <= wdata[8*b +: 8];
          end
          vra_pkg::ACT_ZERO: begin
            vreg_reg[widx][8*b +: 8] <= 8'h00;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Mask register writes, any of the eight
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int k = 0; k < vra_pkg::NUM_MASK_REGS; k++) begin
        kreg_reg[k] <= vra_pkg::MASK_RST;
      end
    end else if (i_ce && i_kw_en) begin
      kreg_reg[i_kw_idx] <= i_kw_data;
    end
  end

  // Registered reads through the chosen view
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= '0;
      o_kr_data <= '0;
    end else if (i_ce) begin
      case (i_rd_view)
        vra_pkg::VIEW_128: begin
          o_rd_data <= {384'h0, vreg_reg[ridx][127:0]};
        end
        vra_pkg::VIEW_256: begin
          o_rd_data <= {256'h0, vreg_reg[ridx][255:0]};
        end
        default: begin
          o_rd_data <= vreg_reg[ridx];
        end
      endcase
      o_kr_data <= kreg_reg[i_kr_idx];
    end
  end

  // Element enables and exception gating
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_elem_en <= '0;
      o_exc_any <= 1'b0;
    end else if (i_ce) begin
      o_elem_en <= elem_en;
      o_exc_any <= |(i_elem_exc & elem_en);
    end
  end

  // Rounding mode and displacement
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rnd_mode <= 2'h0;
      o_disp     <= '0;
    end else if (i_ce) begin
      o_rnd_mode <= use_static ? i_op.rc_mode : i_fpcsr_rc;
      if (i_op.disp8_mode) begin
        o_disp <= 32'(int'($signed(i_op.disp8)) * dscale);
      end else begin
        o_disp <= i_op.full_displacement;
      end
    end
  end

  // Checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  // Legacy writes leave everything above the vec128 view alone
  AST_LEGACY_KEEPS_UPPER: assert property (
    i_ce && i_wr_en && i_op.enc == vra_pkg::ENC_LEGACY |=>
      vreg_reg[$past(widx)][511:128] == $past(vreg_reg[widx][511:128]))
    else $error("legacy write changed upper bits");

  // Short prefix at 128 clears all bits above the vec128 view
  AST_SHORT128_ZEROES: assert property (
    i_ce && i_wr_en && i_op.enc == vra_pkg::ENC_SHORT_128 |=>
      vreg_reg[$past(widx)][511:128] == 384'h0 &&
      vreg_reg[$past(widx)][127:0] == $past(wdata[127:0]))
    else $error("short 128 write wrong");

  // Non-scalar short prefix at 256 writes the low half and clears the rest
  AST_SHORT256_ZEROES: assert property (
    i_ce && i_wr_en && i_op.enc == vra_pkg::ENC_SHORT_256 |=>
      vreg_reg[$past(widx)] == {256'h0, $past(wdata[255:0])})
    else $error("short 256 write wrong");

  // An unmasked non-scalar 512-bit write reaches every byte
  AST_EXT512_FULL: assert property (
    i_ce && i_wr_en && i_op.enc == vra_pkg::ENC_EXT_512 &&
      i_op.mask_sel == vra_pkg::MASK_NONE |=>
      vreg_reg[$past(widx)] == $past(wdata))
    else $error("unmasked 512 write wrong");

  // A vec128 read matches the low bits of a full read that follows
  AST_VIEW128_ALIAS: assert property (
    i_ce && i_rd_view == vra_pkg::VIEW_128 && !(i_wr_en && widx == ridx) ##1
      i_ce && !i_wr_en && i_rd_view == vra_pkg::VIEW_512 && ridx == $past(ridx) |=>
      o_rd_data[127:0] == $past(o_rd_data[127:0]) && $past(o_rd_data[511:128]) == 384'h0)
    else $error("vec128 view differs from full register");

  // Predicate field zero enables all eight quadword elements
  AST_NO_MASK_ALL_ON: assert property (
    i_ce && i_op.enc == vra_pkg::ENC_EXT_512 && i_op.esz == vra_pkg::ESZ_64 &&
      !i_op.scalar && i_op.mask_sel == vra_pkg::MASK_NONE |=> o_elem_en == 64'hff)
    else $error("predicate field zero must not mask");

  // Flags on inactive elements never reach the exception output
  AST_MASKED_NO_EXC: assert property (
    i_ce && (i_elem_exc & elem_en) == 64'h0 |=> !o_exc_any)
    else $error("exception from masked element");

  // Merging keeps an inactive element zero
  AST_MERGE_KEEPS: assert property (
    i_ce && i_wr_en && i_op.enc == vra_pkg::ENC_EXT_512 && i_op.esz == vra_pkg::ESZ_64 &&
      i_op.mask_sel != vra_pkg::MASK_NONE && !kreg_reg[i_op.mask_sel][0] && !i_op.zeroing |=>
      vreg_reg[$past(widx)][63:0] == $past(vreg_reg[widx][63:0]))
    else $error("merging changed masked element");

  // A prefix rounding mode wins over the control register
  AST_RND_OVERRIDE: assert property (
    i_ce && use_static |=> o_rnd_mode == $past(i_op.rc_mode))
    else $error("prefix rounding not applied");

  // A mask write lands in the addressed register
  AST_MASK_WRITE: assert property (
    i_ce && i_kw_en |=> kreg_reg[$past(i_kw_idx)] == $past(i_kw_data))
    else $error("mask write lost");

  // A frozen edge neither writes a mask nor moves the read data, mask read or element-enable outputs
  AST_CE_FREEZE: assert property (
    !i_ce && i_kw_en |=> kreg_reg[$past(i_kw_idx)] == $past(kreg_reg[i_kw_idx]) &&
      $stable(o_rd_data) && $stable(o_kr_data) && $stable(o_elem_en))
    else $error("state moved while clock enable low");

  // Mask reads return the value before any same-edge write
  AST_MASK_READ: assert property (
    i_ce |=> o_kr_data == $past(kreg_reg[i_kr_idx]))
    else $error("mask read data wrong");

  // The vec256 view is the low half of the full register
  AST_VIEW256_READ: assert property (
    i_ce && i_rd_view == vra_pkg::VIEW_256 |=>
      o_rd_data[511:256] == 256'h0 && o_rd_data[255:0] == $past(vreg_reg[ridx][255:0]))
    else $error("vec256 view differs from full register");

  // No element above the element count is ever enabled
  AST_ELEM_COUNT: assert property (
    i_ce |=> (o_elem_en >> $past(nelem)) == 64'h0)
    else $error("element enabled above element count");

  // Without compression the full displacement passes unchanged
  AST_DISP_FULL: assert property (
    i_ce && !i_op.disp8_mode |=> o_disp == $past(i_op.full_displacement))
    else $error("full displacement altered");

  // Zeroing clears an inactive element zero
  AST_ZEROING_CLEARS: assert property (
    i_ce && i_wr_en && i_op.enc == vra_pkg::ENC_EXT_512 && i_op.esz == vra_pkg::ESZ_64 &&
      i_op.mask_sel != vra_pkg::MASK_NONE && !kreg_reg[i_op.mask_sel][0] && i_op.zeroing |=>
      vreg_reg[$past(widx)][63:0] == 64'h0)
    else $error("zeroing left masked element");

  // Without a prefix rounding mode the control register decides
  AST_RND_CONTROL: assert property (
    i_ce && !use_static |=> o_rnd_mode == $past(i_fpcsr_rc))
    else $error("control rounding not applied");

  // Legacy writes still fill the vec128 view
  AST_LEGACY_LOW: assert property (
    i_ce && i_wr_en && i_op.enc == vra_pkg::ENC_LEGACY |=>
      vreg_reg[$past(widx)][127:0] == $past(wdata[127:0]))
    else $error("legacy write lost low bits");

  // Any exception on an active element is reported
  AST_EXC_ACTIVE: assert property (
    i_ce && (i_elem_exc & elem_en) != 64'h0 |=> o_exc_any)
    else $error("exception from active element lost");

  // Main scenarios that the bench is expected to reach
  COV_MERGE: cover property (i_ce && i_wr_en && i_op.mask_sel != 3'h0 && !i_op.zeroing);
  COV_ZERO: cover property (i_ce && i_wr_en && i_op.mask_sel != 3'h0 && i_op.zeroing);
  COV_BCAST: cover property (i_ce && i_wr_en && i_op.bcast);
  COV_DISP8: cover property (i_ce && i_op.disp8_mode);
  COV_MODE32: cover property (i_ce && i_wr_en && !i_mode64);

endmodule : vra_regfile

// File: tb/vra_pipe_model.sv
// Execute-side model that feeds raw exception flags and the control rounding field
module vra_pipe_model (
  input  wire logic        i_mclk,      // Core clock
  input  wire logic        i_arst_n,    // Async reset, active low
  output logic      [63:0] o_elem_exc,  // Raw per-element exception flags
  output logic      [1:0]  o_fpcsr_rc   // Rounding field of fp_control_status_reg
);
  timeunit 1ns;
  timeprecision 100ps;

  // Flags change every cycle, so masked-off lanes carry set flags often
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_elem_exc <= 64'h8f03a5c3_0f0f1e2d;
    end else begin
      o_elem_exc <= {o_elem_exc[62:0], o_elem_exc[63] ^ o_elem_exc[62] ^ o_elem_exc[60]};
    end
  end

  // Control rounding field steps through all four codes
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_fpcsr_rc <= 2'h0;
    end else begin
      o_fpcsr_rc <= o_fpcsr_rc + 2'h1;
    end
  end
endmodule : vra_pipe_model

// File: tb/vra_regfile_tb.sv
// Self-checking bench for the aliased vector register file
module vra_regfile_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic               mclk, arst_n, ce, mode64;     // Clock, reset, enables
  vra_pkg::vra_op_t   op;                           // Instruction controls
  logic               wr_en, kw_en, exc_any;        // Strobes and exception flag
  logic [4:0]         wr_idx, rd_idx;               // Register indices
  logic [511:0]       wr_data, rd_data;             // Vector data
  vra_pkg::vra_view_t rd_view;                      // Read view width
  logic [2:0]         kw_idx, kr_idx;               // Mask indices
  logic [63:0]        kw_data, kr_data, elem_exc, elem_en; // Mask and element buses
  logic [1:0]         fpcsr_rc, rnd_mode;           // Rounding codes
  logic [31:0]        disp;                         // Effective displacement
  logic [511:0]       vreg [32];                    // Reference vector registers
  logic [63:0]        kreg [8];                     // Reference mask registers
  int                 bad_count, cmp_count;         // Report counters

  // Free-running core clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  vra_regfile u_dut (.i_mclk(mclk), .i_arst_n(arst_n), .i_ce(ce), .i_mode64(mode64), .i_op(op),
    .i_wr_en(wr_en), .i_wr_idx(wr_idx), .i_wr_data(wr_data), .i_rd_idx(rd_idx),
    .i_rd_view(rd_view), .i_kw_en(kw_en), .i_kw_idx(kw_idx), .i_kw_data(kw_data),
    .i_kr_idx(kr_idx), .i_fpcsr_rc(fpcsr_rc), .i_elem_exc(elem_exc), .o_rd_data(rd_data),
    .o_kr_data(kr_data), .o_elem_en(elem_en), .o_exc_any(exc_any), .o_rnd_mode(rnd_mode),
    .o_disp(disp));

  vra_pipe_model u_pipe (.i_mclk(mclk), .i_arst_n(arst_n), .o_elem_exc(elem_exc),
    .o_fpcsr_rc(fpcsr_rc));

  // Compare and count
  task automatic chk(input logic [511:0] got, input logic [511:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t %s", $time, what);
    end
  endtask : chk

  // Print counts and verdict, then stop
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  // Class helpers for the reference model
  function automatic logic is_ext(input vra_pkg::vra_enc_t e);
    return e inside {vra_pkg::ENC_EXT_128, vra_pkg::ENC_EXT_256, vra_pkg::ENC_EXT_512};
  endfunction : is_ext

  function automatic int len_b(input vra_pkg::vra_enc_t e);
    if (e inside {vra_pkg::ENC_SHORT_256, vra_pkg::ENC_EXT_256}) return 32;
    return (e == vra_pkg::ENC_EXT_512) ? 64 : 16;
  endfunction : len_b

  function automatic logic [4:0] eff(input logic [4:0] i);
    return mode64 ? i : {2'h0, i[2:0]};
  endfunction : eff

  function automatic logic [511:0] rnd512();
    logic [511:0] r;
    for (int i = 0; i < 16; i++) r[32*i+:32] = $urandom;
    return r;
  endfunction : rnd512

  function automatic vra_pkg::vra_op_t rnd_op(input logic we);
    vra_pkg::vra_op_t o;
    o = vra_pkg::vra_op_t'(56'({$urandom, $urandom}));
    o.enc = vra_pkg::vra_enc_t'($urandom_range(0, 5));
    if (we) o.scalar = 1'b0;
    if (!is_ext(o.enc)) o.bcast = 1'b0;
    return o;
  endfunction : rnd_op

  // One op with optional write, then a read back of one register
  task automatic run_op(input vra_pkg::vra_op_t o, input logic we, input logic [4:0] wi,
                        input logic [4:0] ri, input int v, input logic [511:0] d,
                        input logic m64);
    logic [63:0]  pred, en_x, exc_s;
    logic [511:0] nv, vm;
    logic [1:0]   rc_s, rc_x;
    int           eb, L, n, dv;
    @(posedge mclk);
    op <= o;
    wr_en <= we;
    wr_idx <= wi;
    wr_data <= d;
    mode64 <= m64;
    @(posedge mclk);
    exc_s = elem_exc;
    rc_s = fpcsr_rc;
    wr_en <= 1'b0;
    rd_idx <= ri;
    rd_view <= vra_pkg::vra_view_t'(v);
    eb = 1 << int'(o.esz);
    L = len_b(o.enc);
    n = o.scalar ? 1 : L / eb;
    pred = (is_ext(o.enc) && o.mask_sel != vra_pkg::MASK_NONE) ? kreg[o.mask_sel] : '1;
    en_x = '0;
    for (int i = 0; i < n; i++) en_x[i] = pred[i];
    nv = vreg[eff(wi)];
    for (int b = 0; b < 64; b++) begin
      if (o.enc == vra_pkg::ENC_LEGACY && b >= 16) continue;
      if (b >= L || (!pred[b >> o.esz] && o.zeroing)) nv[8*b+:8] = 8'h0;
      else if (pred[b >> o.esz]) nv[8*b+:8] = o.bcast ? d[8*(b % eb)+:8] : d[8*b+:8];
    end
    if (we) vreg[eff(wi)] = nv;
    dv = int'($signed(o.disp8)) * ((o.bcast || o.scalar) ? eb : L);
    #1;
    chk(elem_en, en_x, "element enables");
    chk(exc_any, |(exc_s & en_x), "exception");
    rc_x = (is_ext(o.enc) && o.rr_form && o.rc_static &&
            (o.enc == vra_pkg::ENC_EXT_512 || o.scalar)) ? o.rc_mode : rc_s;
    chk(rnd_mode, rc_x, "rounding");
    chk(disp, o.disp8_mode ? 32'(dv) : o.full_displacement, "displacement");
    @(posedge mclk);
    #1;
    vm = {512{1'b1}} >> ((v == 0) ? 384 : (v == 1) ? 256 : 0);
    chk(rd_data, vreg[eff(ri)] & vm, "read data");
  endtask : run_op

  // Mask write, optionally frozen by clock enable, then read back
  task automatic kwrite(input logic [2:0] k, input logic [63:0] dta, input logic en);
    @(posedge mclk);
    kw_en <= 1'b1;
    kw_idx <= k;
    kw_data <= dta;
    ce <= en;
    @(posedge mclk);
    kw_en <= 1'b0;
    kr_idx <= k;
    ce <= 1'b1;
    if (en) kreg[k] = dta;
    @(posedge mclk);
    #1;
    chk(kr_data, kreg[k], "mask readback");
  endtask : kwrite

  // Main sequence
  initial begin
    vra_pkg::vra_op_t  o;
    vra_pkg::vra_enc_t encs [6];
    void'($urandom(32'h5167494f));
    encs = '{vra_pkg::ENC_EXT_512, vra_pkg::ENC_LEGACY, vra_pkg::ENC_SHORT_128,
             vra_pkg::ENC_EXT_512, vra_pkg::ENC_SHORT_256, vra_pkg::ENC_EXT_256};
    {arst_n, wr_en, kw_en, wr_idx, rd_idx, kw_idx, kr_idx} = '0;
    {wr_data, kw_data} = '0;
    ce = 1'b1;
    mode64 = 1'b1;
    op = '0;
    rd_view = vra_pkg::VIEW_512;
    foreach (vreg[i]) vreg[i] = vra_pkg::VREG_RST;
    foreach (kreg[i]) kreg[i] = vra_pkg::MASK_RST;
    repeat (5) @(posedge mclk);
    #1;
    chk(rd_data, '0, "reset read data");
    chk({elem_en, kr_data, exc_any, rnd_mode, disp}, '0, "reset outputs");
    @(posedge mclk);
    arst_n <= 1'b1;
    for (int k = 0; k < 8; k++) kwrite(3'(k), {$urandom, $urandom}, k != 5);
    $display("test masks done");
    for (int s = 0; s < 6; s++) begin
      o = '0;
      o.enc = encs[s];
      for (int v = 0; v < 3; v++) run_op(o, v == 0, 5'h3, 5'h3, v, rnd512(), 1'b1);
    end
    $display("test views done");
    for (int e = 0; e < 6; e++) begin
      for (int z = 0; z < 4; z++) begin
        o = rnd_op(1'b1);
        o.enc = vra_pkg::vra_enc_t'(e);
        o.esz = vra_pkg::vra_esz_t'(z);
        o.bcast = o.bcast & is_ext(o.enc);
        run_op(o, 1'b1, 5'(e * 4 + z), 5'(e * 4 + z), 2, rnd512(), 1'b1);
      end
    end
    $display("test classes done");
    repeat (300) begin
      o = rnd_op(1'b1);
      run_op(rnd_op(1'b0), 1'b0, 5'($urandom), 5'($urandom), $urandom_range(0, 2), '0, 1'b1);
      run_op(o, 1'b1, 5'($urandom), 5'($urandom), $urandom_range(0, 2), rnd512(),
             $urandom_range(0, 3) != 0);
    end
    $display("test random done");
    final_report();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    final_report();
  end
endmodule : vra_regfile_tb
